// ### rtl/acqseq_pkg.sv
/*
 * Shared constants of the single-channel acquisition sequencer:
 * register offsets, field positions, counter mode codes and clock rates.
 * Assumes a byte-wide register port and a 25 MHz core clock.
 */
package acqseq_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  OFS_STATUS_CFG  = 4'h0;  // read status, write config
	localparam logic [3:0]  OFS_TRIGGER     = 4'h1;
	localparam logic [3:0]  OFS_FIFO        = 4'h2;
	localparam logic [3:0]  OFS_CLEAR       = 4'h3;
	localparam logic [3:0]  OFS_INTERVAL    = 4'h4;
	localparam logic [3:0]  OFS_SAMPLE      = 4'h5;
	localparam logic [3:0]  OFS_GROUP_A_MODE = 4'h7;
	localparam logic [3:0]  OFS_TIMEBASE    = 4'h8;
	localparam logic [3:0]  OFS_GROUP_B_MODE = 4'hB;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_TIMEBASE_SELECT = 0;
	localparam int BIT_SCAN_ENABLE     = 1;
	localparam int BIT_SW_TRIGGER      = 0;
	localparam int BIT_DATA_AVAIL      = 0;
	localparam int BIT_OVERFLOW        = 1;
	localparam int BIT_OVERRUN         = 2;
	localparam int BIT_SAMPLE_OUT      = 3;
	localparam int BIT_INTERVAL_OUT    = 4;

	// ----------------------------------------------------------------
	// Counter mode control bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_CMD_INTERVAL = 8'h34;
	localparam logic [7:0] MODE_CMD_SAMPLE   = 8'h70;
	localparam logic [7:0] MODE_CMD_TIMEBASE = 8'h36;
	localparam logic [7:0] MODE_SEL_SAMPLE   = 8'h40;  // select field of group A
	localparam logic [7:0] MODE_SEL_MASK     = 8'hC0;

	typedef enum logic [1:0] {
		ACQSEQ_TERMINAL = 2'b00,
		ACQSEQ_RATE     = 2'b01,
		ACQSEQ_SQUARE   = 2'b11
	} acqseq_mode_t;

	// ----------------------------------------------------------------
	// Clocks and timing
	// ----------------------------------------------------------------
	localparam int CORE_CLK_NS   = 40;
	localparam int TB_FIXED_NS   = 1000;                        // 1 MHz source
	localparam int TB_FIXED_DIV  = TB_FIXED_NS / CORE_CLK_NS;
	localparam int CORE_MHZ      = 25;
	localparam int TB_FAST_MHZ   = 2;                           // 500 ns source
	localparam int FIFO_DEPTH    = 16;
	localparam int RESULT_W      = 16;

	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [15:0] RESET_WORD  = 16'h0000;

endpackage

// ### rtl/acqseq_counter.sv
/*
 * One sixteen-bit down counter with terminal, rate and square-wave modes,
 * loaded low byte then high byte. Advances on a one-cycle tick enable.
 * Assumes tick, gate and the write strobes are synchronous to clk.
 */
`timescale 1ns/1ns
module acqseq_counter
	import acqseq_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         tick,
	input  wire logic         gate,
	input  wire logic         mode_wr,
	input  acqseq_mode_t      mode,
	input  wire logic         data_wr,
	input  wire logic [7:0]   data,
	output logic              out,
	output logic              out_fall,
	output logic              out_rise
);

	acqseq_mode_t  mode_ff;
	logic          byte_hi_ff;
	logic [7:0]    lsb_ff;
	logic [15:0]   reload_ff;
	logic [15:0]   count_ff;
	logic          pend_ff;
	logic          loaded_ff;
	logic          out_ff;
	logic          out_prev_ff;
	logic          gate_prev_ff;

	assign out      = out_ff;
	assign out_fall = out_prev_ff & ~out_ff;
	assign out_rise = ~out_prev_ff & out_ff;

	// ----------------------------------------------------------------
	// Programming path
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff    <= ACQSEQ_TERMINAL;
			byte_hi_ff <= 1'b0;
			lsb_ff     <= RESET_BYTE;
			reload_ff  <= RESET_WORD;
		end else if (mode_wr) begin
			mode_ff    <= mode;
			byte_hi_ff <= 1'b0;
		end else if (data_wr) begin
			byte_hi_ff <= ~byte_hi_ff;
			if (!byte_hi_ff)
				lsb_ff <= data;
			else
				reload_ff <= {data, lsb_ff};
		end
	end

	// ----------------------------------------------------------------
	// Counting path
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_ff     <= RESET_WORD;
			pend_ff      <= 1'b0;
			loaded_ff    <= 1'b0;
			out_ff       <= 1'b1;
			out_prev_ff  <= 1'b1;
			gate_prev_ff <= 1'b0;
		end else begin
			out_prev_ff  <= out_ff;
			gate_prev_ff <= gate;
			if (mode_wr) begin
				// terminal mode output low until count ends
				out_ff    <= (mode == ACQSEQ_TERMINAL) ? 1'b0 : 1'b1;
				loaded_ff <= 1'b0;
				pend_ff   <= 1'b0;
			end else if (data_wr && byte_hi_ff) begin
				pend_ff <= 1'b1;
			end else if (mode_ff != ACQSEQ_TERMINAL && !gate) begin
				out_ff <= 1'b1;
				if (gate_prev_ff)
					count_ff <= reload_ff;
			end else if (tick) begin
				if (pend_ff) begin
					count_ff  <= reload_ff;
					pend_ff   <= 1'b0;
					loaded_ff <= 1'b1;
				end else if (loaded_ff && gate) begin
					case (mode_ff)
						ACQSEQ_TERMINAL: begin
							if (count_ff == 16'h0000)
								out_ff <= 1'b1;
							else
								count_ff <= count_ff - 16'h0001;
						end
						ACQSEQ_RATE: begin
							// one low tick per period of N
							if (count_ff == 16'h0002) begin
								out_ff   <= 1'b0;
								count_ff <= 16'h0001;
							end else if (count_ff <= 16'h0001) begin
								out_ff   <= 1'b1;
								count_ff <= reload_ff;
							end else begin
								count_ff <= count_ff - 16'h0001;
							end
						end
						ACQSEQ_SQUARE: begin
							if (count_ff <= 16'h0002) begin
								out_ff   <= ~out_ff;
								count_ff <= reload_ff;
							end else begin
								count_ff <= count_ff - 16'h0002;
							end
						end
						default: begin
							out_ff <= 1'b1;
						end
					endcase
				end
			end
		end
	end

endmodule

// ### rtl/acqseq_top.sv
/*
 * Single-channel acquisition sequencer: interval, sample and timebase
 * counters, conversion start logic, sixteen-entry result FIFO and status.
 * Assumes a byte register port synchronous to core_clk, and an external
 * converter that answers each conv_start with one adc_valid pulse.
 */
// The address map and the plain strobed port are this design's own decisions.
//
// Operation
// - Controlled mode paces, counts, then stops conversions
// - Controlled count held in sixteen bits
// - Freerun pulses continue while gate high
// - Interval clock is 1 MHz after reset
// - Timebase select uses timebase counter output
// - Timebase counter runs from fixed 2 MHz
// - Sample period equals timebase period times N
// - Interval falling edge starts one conversion
// - Interval divisor N ranges 2 to 65535
// - Sample counter tallies conversions, halts interval counter
// - Programmed interval output rests high
// - Software trigger bit starts interval counting
// - Data available flag at status bit 0
// - Full FIFO drops result, sets overflow
// - Start during conversion sets overrun
// - Clear write resets overflow and overrun
// - Enable only with trigger and sample low
// - FIFO result read low then high byte
`timescale 1ns/1ns
module acqseq_top
	import acqseq_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata,
	input  wire logic                 external_convert_input_n,
	output logic                      conv_start,
	input  wire logic                 adc_valid,
	input  wire logic [RESULT_W-1:0]  adc_data,
	output logic                      channel_scan_enable_bit
);

	localparam int PTR_W = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic wr_cfg, wr_trig, wr_clear, wr_ival, wr_samp, wr_amode, wr_tb, wr_bmode;
	logic rd_fifo;
	logic wr_ival_mode, wr_samp_mode;

	assign wr_cfg   = reg_wr && reg_addr == OFS_STATUS_CFG;
	assign wr_trig  = reg_wr && reg_addr == OFS_TRIGGER;
	assign wr_clear = reg_wr && reg_addr == OFS_CLEAR;
	assign wr_ival  = reg_wr && reg_addr == OFS_INTERVAL;
	assign wr_samp  = reg_wr && reg_addr == OFS_SAMPLE;
	assign wr_amode = reg_wr && reg_addr == OFS_GROUP_A_MODE;
	assign wr_tb    = reg_wr && reg_addr == OFS_TIMEBASE;
	assign wr_bmode = reg_wr && reg_addr == OFS_GROUP_B_MODE;
	assign rd_fifo  = reg_rd && reg_addr == OFS_FIFO;

	assign wr_samp_mode = wr_amode && (reg_wdata & MODE_SEL_MASK) == MODE_SEL_SAMPLE;
	assign wr_ival_mode = wr_amode && !wr_samp_mode;

	// ----------------------------------------------------------------
	// Control bits
	// ----------------------------------------------------------------
	logic timebase_select_bit_ff;
	logic scan_enable_ff;
	logic software_trigger_bit_ff;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			timebase_select_bit_ff  <= 1'b0;
			scan_enable_ff          <= 1'b0;
			software_trigger_bit_ff <= 1'b0;
		end else begin
			if (wr_cfg) begin
				timebase_select_bit_ff <= reg_wdata[BIT_TIMEBASE_SELECT];
				scan_enable_ff         <= reg_wdata[BIT_SCAN_ENABLE];
			end
			if (wr_trig)
				software_trigger_bit_ff <= reg_wdata[BIT_SW_TRIGGER];
		end
	end

	assign channel_scan_enable_bit = scan_enable_ff;

	// ----------------------------------------------------------------
	// Fixed timebases
	// ----------------------------------------------------------------
	logic [4:0] div_1m_ff;
	logic       tick_1m_ff;
	logic [4:0] acc_2m_ff;
	logic       tick_2m_ff;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_1m_ff  <= 5'h00;
			tick_1m_ff <= 1'b0;
		end else if (div_1m_ff == 5'(TB_FIXED_DIV - 1)) begin
			div_1m_ff  <= 5'h00;
			tick_1m_ff <= 1'b1;
		end else begin
			div_1m_ff  <= div_1m_ff + 5'h01;
			tick_1m_ff <= 1'b0;
		end
	end

	// fractional divider averages exactly 2 MHz
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc_2m_ff  <= 5'h00;
			tick_2m_ff <= 1'b0;
		end else if (acc_2m_ff >= 5'(CORE_MHZ - TB_FAST_MHZ)) begin
			acc_2m_ff  <= acc_2m_ff - 5'(CORE_MHZ - TB_FAST_MHZ);
			tick_2m_ff <= 1'b1;
		end else begin
			acc_2m_ff  <= acc_2m_ff + 5'(TB_FAST_MHZ);
			tick_2m_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	logic interval_counter_output, interval_fall;
	logic sample_counter_output;
	logic timebase_rise;
	logic interval_tick;
	logic interval_counter_gate;
	acqseq_mode_t ival_mode, samp_mode;

	// enable needs trigger set and sample output low
	// terminal count high holds interval counter off
	// trigger bit lets interval counter run
	assign interval_counter_gate = software_trigger_bit_ff && !sample_counter_output;
	// interval ticks once per timebase period when select is set, else on the 1 MHz tick
	assign interval_tick = timebase_select_bit_ff ? timebase_rise : tick_1m_ff;
	assign ival_mode = ACQSEQ_RATE;
	assign samp_mode = ACQSEQ_TERMINAL;

	// free running while gate stays high
	acqseq_counter u_interval_counter (
		.clk      (core_clk),
		.rstn     (rstn),
		.tick     (interval_tick),
		.gate     (interval_counter_gate),
		.mode_wr  (wr_ival_mode),
		.mode     (ival_mode),
		.data_wr  (wr_ival),
		.data     (reg_wdata),
		.out      (interval_counter_output),
		.out_fall (interval_fall),
		.out_rise ()
	);

	// counts conversion pulses from interval counter
	acqseq_counter u_sample_counter (
		.clk      (core_clk),
		.rstn     (rstn),
		.tick     (interval_fall),
		.gate     (1'b1),
		.mode_wr  (wr_samp_mode),
		.mode     (samp_mode),
		.data_wr  (wr_samp),
		.data     (reg_wdata),
		.out      (sample_counter_output),
		.out_fall (),
		.out_rise ()
	);

	acqseq_counter u_timebase_counter (
		.clk      (core_clk),
		.rstn     (rstn),
		.tick     (tick_2m_ff),
		.gate     (1'b1),
		.mode_wr  (wr_bmode),
		.mode     (ACQSEQ_SQUARE),
		.data_wr  (wr_tb),
		.data     (reg_wdata),
		.out      (),
		.out_fall (),
		.out_rise (timebase_rise)
	);

	// ----------------------------------------------------------------
	// Conversion start and overrun
	// ----------------------------------------------------------------
	logic ext_prev_ff;
	logic ext_fall;
	logic start_req;
	logic conv_start_ff;
	logic busy_ff;
	logic overrun_ff;

	assign ext_fall  = ext_prev_ff && !external_convert_input_n && interval_counter_gate;
	// falling edge of interval output starts a conversion
	assign start_req = interval_fall || ext_fall;
	assign conv_start = conv_start_ff;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ext_prev_ff   <= 1'b1;
			conv_start_ff <= 1'b0;
			busy_ff       <= 1'b0;
		end else begin
			ext_prev_ff   <= external_convert_input_n;
			conv_start_ff <= start_req;
			if (conv_start_ff)
				busy_ff <= 1'b1;
			else if (adc_valid)
				busy_ff <= 1'b0;
		end
	end

	// new start while converting sets overrun
	// clear write resets, a same-cycle event wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			overrun_ff <= 1'b0;
		else if (conv_start_ff && busy_ff && !adc_valid)
			overrun_ff <= 1'b1;
		else if (wr_clear)
			overrun_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Result FIFO
	// ----------------------------------------------------------------
	logic [RESULT_W-1:0] mem_ff [DEPTH];
	logic [PTR_W-1:0]    wptr_ff, rptr_ff;
	logic [PTR_W:0]      level_ff;
	logic                byte_hi_ff;
	logic                overflow_ff;
	logic                fifo_full, fifo_empty, push, pop;

	assign fifo_full  = level_ff == (PTR_W+1)'(DEPTH);
	assign fifo_empty = level_ff == '0;
	assign push = adc_valid && !fifo_full;
	// second byte read removes the entry
	assign pop  = rd_fifo && byte_hi_ff && !fifo_empty;

	// full FIFO keeps contents, drops new result
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_mem
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn)
					mem_ff[i] <= RESET_WORD;
				else if (push && wptr_ff == PTR_W'(i))
					mem_ff[i] <= adc_data;
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wptr_ff    <= '0;
			rptr_ff    <= '0;
			level_ff   <= '0;
			byte_hi_ff <= 1'b0;
		end else if (wr_clear) begin
			wptr_ff    <= '0;
			rptr_ff    <= '0;
			level_ff   <= '0;
			byte_hi_ff <= 1'b0;
		end else begin
			if (push)
				wptr_ff <= wptr_ff + PTR_W'(1);
			if (pop)
				rptr_ff <= rptr_ff + PTR_W'(1);
			if (push && !pop)
				level_ff <= level_ff + (PTR_W+1)'(1);
			else if (pop && !push)
				level_ff <= level_ff - (PTR_W+1)'(1);
			// low byte first, then high byte
			if (rd_fifo)
				byte_hi_ff <= ~byte_hi_ff;
		end
	end

	// clear write resets, a same-cycle event wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			overflow_ff <= 1'b0;
		else if (adc_valid && fifo_full)
			overflow_ff <= 1'b1;
		else if (wr_clear)
			overflow_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0] status_byte;
	logic [7:0] rdata_ff;
	logic [RESULT_W-1:0] head;

	assign head = mem_ff[rptr_ff];

	// data available flag in status bit 0
	always_comb begin
		status_byte = RESET_BYTE;
		status_byte[BIT_DATA_AVAIL]   = !fifo_empty;
		status_byte[BIT_OVERFLOW]     = overflow_ff;
		status_byte[BIT_OVERRUN]      = overrun_ff;
		status_byte[BIT_SAMPLE_OUT]   = sample_counter_output;
		status_byte[BIT_INTERVAL_OUT] = interval_counter_output;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rdata_ff <= RESET_BYTE;
		else if (reg_rd) begin
			case (reg_addr)
				OFS_STATUS_CFG: rdata_ff <= status_byte;
				OFS_TRIGGER:    rdata_ff <= {7'h00, software_trigger_bit_ff};
				OFS_FIFO:       rdata_ff <= byte_hi_ff ? head[15:8] : head[7:0];
				default:        rdata_ff <= RESET_BYTE;
			endcase
		end
	end

	assign reg_rdata = rdata_ff;

endmodule

// ### verif/acqseq_adc_model.sv
/*
 * Behavioural converter on the far side of conv_start.
 * Assumes one result is owed for each conv_start, in order, after latency cycles.
 */
`timescale 1ns/1ns
module acqseq_adc_model
	import acqseq_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                conv_start,
	input  wire logic [15:0]         latency,
	output logic                     adc_valid,
	output logic      [RESULT_W-1:0] adc_data
);
	logic [15:0] cyc_ff;
	logic [7:0]  seq_ff;
	logic [15:0] due_q[$];

	// Result n carries n in its low byte and its inverse in its high byte
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cyc_ff <= 16'h0000;
			seq_ff <= 8'h00;
			adc_valid <= 1'b0;
			adc_data <= 16'h0000;
			due_q.delete();
		end else begin
			cyc_ff <= cyc_ff + 16'h0001;
			if (conv_start) begin
				due_q.push_back(cyc_ff + latency);
			end
			if (due_q.size() > 0 && due_q[0] == cyc_ff) begin
				void'(due_q.pop_front());
				adc_valid <= 1'b1;
				adc_data <= {~seq_ff, seq_ff};
				seq_ff <= seq_ff + 8'h01;
			end else begin
				// Bus toggles between results so stale data never looks valid
				adc_valid <= 1'b0;
				adc_data <= ~adc_data;
			end
		end
	end
endmodule

// ### verif/acqseq_top_asserts.sv
/*
 * Port checker of the acquisition sequencer.
 * Assumes it is bound to acqseq_top and sees only its ports.
 */
`timescale 1ns/1ns
module acqseq_top_asserts
	import acqseq_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic                core_clk,
	input wire logic                rstn,
	input wire logic [ADDR_W-1:0]   reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [7:0]          reg_rdata,
	input wire logic                external_convert_input_n,
	input wire logic                conv_start,
	input wire logic                adc_valid,
	input wire logic [RESULT_W-1:0] adc_data,
	input wire logic                channel_scan_enable_bit
);
	logic trig_ff;
	logic quiet;
	logic st_rd;

	assign quiet = !adc_valid && !conv_start;
	assign st_rd = reg_rd && reg_addr == OFS_STATUS_CFG;

	// Shadow of the software trigger bit
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trig_ff <= 1'b0;
		end else if (reg_wr && reg_addr == OFS_TRIGGER) begin
			trig_ff <= reg_wdata[BIT_SW_TRIGGER];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("conv_start longer than one cycle");
	a_no_start_untrig: assert property ((!trig_ff) [*4] |-> !conv_start)
		else $error("conversion started with trigger bit clear");
	a_trig_readback: assert property (reg_rd && reg_addr == OFS_TRIGGER
		|=> reg_rdata[BIT_SW_TRIGGER] == $past(trig_ff))
		else $error("trigger bit read back wrong");
	a_dav_after_valid: assert property (adc_valid && !reg_wr ##1 (st_rd
		or (!reg_wr && !reg_rd ##1 st_rd)) |=> reg_rdata[BIT_DATA_AVAIL])
		else $error("data available flag clear after a result");
	a_clear_flags: assert property ($past(quiet) && quiet && reg_wr
		&& reg_addr == OFS_CLEAR ##1 quiet ##1 (st_rd && quiet)
		|=> reg_rdata[BIT_OVERRUN:BIT_OVERFLOW] == 2'b00)
		else $error("error flags survive a clear write");
	a_unmapped_zero: assert property (reg_rd && reg_addr inside {4'h6, 4'h9, 4'hA,
		4'hC, 4'hD, 4'hE, 4'hF} |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	a_scan_bit: assert property (reg_wr && reg_addr == OFS_STATUS_CFG
		|=> channel_scan_enable_bit == $past(reg_wdata[BIT_SCAN_ENABLE]))
		else $error("scan enable bit not taken from config write");

	c_start: cover property (conv_start);
	c_result: cover property (adc_valid);
	c_overflow: cover property (st_rd ##1 reg_rdata[BIT_OVERFLOW]);
	c_clear: cover property (reg_wr && reg_addr == OFS_CLEAR);
endmodule

bind acqseq_top acqseq_top_asserts #(.DEPTH(DEPTH)) i_chk (
	.core_clk                 (core_clk),
	.rstn                     (rstn),
	.reg_addr                 (reg_addr),
	.reg_wdata                (reg_wdata),
	.reg_wr                   (reg_wr),
	.reg_rd                   (reg_rd),
	.reg_rdata                (reg_rdata),
	.external_convert_input_n (external_convert_input_n),
	.conv_start               (conv_start),
	.adc_valid                (adc_valid),
	.adc_data                 (adc_data),
	.channel_scan_enable_bit  (channel_scan_enable_bit)
);

// ### verif/acqseq_top_tb_top.sv
/*
 * Self-checking bench of the acquisition sequencer with a converter model.
 * Assumes a 25 MHz core clock and the register map of acqseq_pkg.
 */
`timescale 1ns/1ns
module acqseq_top_tb_top;
	import acqseq_pkg::*;

	logic                core_clk = 1'b0;
	logic                rstn = 1'b0;
	logic [ADDR_W-1:0]   reg_addr = 4'h0;
	logic [7:0]          reg_wdata = 8'h00;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic [7:0]          reg_rdata;
	logic                ext_n = 1'b1;
	logic                conv_start;
	logic                adc_valid;
	logic [RESULT_W-1:0] adc_data;
	logic                scan_bit;
	logic [15:0]         lat = 16'h0005;
	int                  err_total = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	int                  conv_cnt = 0;
	int                  start_t[256];

	acqseq_top #(.DEPTH(FIFO_DEPTH)) i_dut (
		.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_convert_input_n(ext_n), .conv_start(conv_start),
		.adc_valid(adc_valid), .adc_data(adc_data), .channel_scan_enable_bit(scan_bit));
	acqseq_adc_model i_adc (.core_clk(core_clk), .rstn(rstn), .conv_start(conv_start),
		.latency(lat), .adc_valid(adc_valid), .adc_data(adc_data));

	initial begin
		forever #20 core_clk = ~core_clk;
	end

	// Start times of every conversion
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (conv_start === 1'b1) begin
			start_t[conv_cnt % 256] <= cyc;
			conv_cnt <= conv_cnt + 1;
		end
	end

	// ----------------------------------------------------------------
	// Register port and checks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic load16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a, v[15:8]);
	endtask
	task automatic rd_fifo(output logic [15:0] v);
		rd(OFS_FIFO, v[7:0]);
		rd(OFS_FIFO, v[15:8]);
	endtask
	task automatic clear_fifo();
		logic [15:0] junk;
		wr(OFS_CLEAR, 8'h00);
		rd_fifo(junk);
	endtask
	task automatic setup(input logic [15:0] n);
		wr(OFS_GROUP_A_MODE, MODE_CMD_INTERVAL);
		load16(OFS_INTERVAL, n);
		wr(OFS_GROUP_A_MODE, MODE_CMD_SAMPLE);
	endtask
	task automatic wait_cnt(input int target, input int limit);
		int k;
		k = 0;
		while (conv_cnt < target && k < limit) begin
			@(posedge core_clk);
			k++;
		end
		chk("conversion count reached", 16'h0001, {15'h0000, conv_cnt >= target});
	endtask
	task automatic drain(input int base, input int n);
		logic [7:0]  s;
		logic [15:0] v;
		logic [7:0]  q;
		for (int i = 0; i < n; i++) begin
			s = 8'h00;
			for (int k = 0; k < 20 && s[BIT_DATA_AVAIL] !== 1'b1; k++) begin
				rd(OFS_STATUS_CFG, s);
			end
			chk("data available", 16'h0001, {15'h0000, s[BIT_DATA_AVAIL]});
			rd_fifo(v);
			q = 8'(base + i);
			chk("fifo result", {~q, q}, v);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_state();
		logic [7:0] s;
		rd(OFS_STATUS_CFG, s);
		chk("status after reset", 16'h0018, {8'h00, s});
		rd(4'hC, s);
		chk("unmapped read", 16'h0000, {8'h00, s});
		rd(OFS_TRIGGER, s);
		chk("trigger after reset", 16'h0000, {8'h00, s});
	endtask
	task automatic t_controlled();
		logic [7:0] s;
		int         b;
		wr(OFS_STATUS_CFG, 8'h00);
		setup(16'h0014);
		load16(OFS_SAMPLE, 16'h0001);
		rd(OFS_STATUS_CFG, s);
		chk("outputs programmed", 16'h0002, {14'h0000, s[BIT_INTERVAL_OUT], s[BIT_SAMPLE_OUT]});
		clear_fifo();
		b = conv_cnt;
		wr(OFS_TRIGGER, 8'h01);
		rd(OFS_TRIGGER, s);
		chk("trigger readback", 16'h0001, {8'h00, s});
		wait_cnt(b + 3, 3000);
		repeat (2000) @(posedge core_clk);
		chk("controlled count", 16'h0003, 16'(conv_cnt - b));
		chk("interval 1 MHz", 16'd500, 16'(start_t[(b + 1) % 256] - start_t[b % 256]));
		chk("interval steady", 16'd500, 16'(start_t[(b + 2) % 256] - start_t[(b + 1) % 256]));
		rd(OFS_STATUS_CFG, s);
		chk("sample output done", 16'h0001, {15'h0000, s[BIT_SAMPLE_OUT]});
		drain(b, 3);
		wr(OFS_TRIGGER, 8'h00);
	endtask
	task automatic t_timebase();
		int b;
		int d;
		wr(OFS_STATUS_CFG, 8'h03);
		chk("scan enable set", 16'h0001, {15'h0000, scan_bit});
		wr(OFS_STATUS_CFG, 8'h01);
		chk("scan enable clear", 16'h0000, {15'h0000, scan_bit});
		wr(OFS_GROUP_B_MODE, MODE_CMD_TIMEBASE);
		load16(OFS_TIMEBASE, 16'h0004);
		setup(16'h0008);
		clear_fifo();
		b = conv_cnt;
		wr(OFS_TRIGGER, 8'h01);
		wait_cnt(b + 4, 3000);
		d = start_t[(b + 3) % 256] - start_t[(b + 1) % 256];
		chk("timebase span", 16'h0001, {15'h0000, d >= 798 && d <= 802});
		wr(OFS_TRIGGER, 8'h00);
		repeat (4) @(posedge core_clk);
		d = conv_cnt;
		repeat (1000) @(posedge core_clk);
		chk("freerun stopped", 16'(d), 16'(conv_cnt));
	endtask
	task automatic t_external();
		int n;
		wr(OFS_STATUS_CFG, 8'h00);
		setup(16'h0014);
		wr(OFS_GROUP_A_MODE, MODE_CMD_INTERVAL);
		wr(OFS_GROUP_A_MODE, MODE_CMD_SAMPLE);
		for (int t = 1; t >= 0; t--) begin
			wr(OFS_TRIGGER, 8'(t));
			n = conv_cnt;
			@(posedge core_clk);
			ext_n <= 1'b0;
			repeat (10) @(posedge core_clk);
			ext_n <= 1'b1;
			repeat (10) @(posedge core_clk);
			chk("external convert", 16'(n + t), 16'(conv_cnt));
		end
	endtask
	task automatic t_overflow();
		logic [7:0]  s;
		int          b;
		setup(16'h0014);
		clear_fifo();
		b = conv_cnt;
		wr(OFS_TRIGGER, 8'h01);
		wait_cnt(b + 18, 12000);
		wr(OFS_TRIGGER, 8'h00);
		repeat (20) @(posedge core_clk);
		rd(OFS_STATUS_CFG, s);
		chk("overflow flags", 16'h0003, {14'h0000, s[BIT_OVERFLOW], s[BIT_DATA_AVAIL]});
		drain(b, 16);
		rd(OFS_STATUS_CFG, s);
		chk("extra result dropped", 16'h0000, {15'h0000, s[BIT_DATA_AVAIL]});
		wr(OFS_CLEAR, 8'h00);
		rd(OFS_STATUS_CFG, s);
		chk("overflow cleared", 16'h0000, {15'h0000, s[BIT_OVERFLOW]});
	endtask
	task automatic t_overrun();
		logic [7:0] s;
		int         b;
		lat = 16'd300;
		setup(16'h0002);
		clear_fifo();
		b = conv_cnt;
		wr(OFS_TRIGGER, 8'h01);
		wait_cnt(b + 3, 1000);
		wr(OFS_TRIGGER, 8'h00);
		repeat (1000) @(posedge core_clk);
		rd(OFS_STATUS_CFG, s);
		chk("overrun flag", 16'h0001, {15'h0000, s[BIT_OVERRUN]});
		wr(OFS_CLEAR, 8'h00);
		rd(OFS_STATUS_CFG, s);
		chk("flags after clear", 16'h0000, {13'h0000, s[2:0]});
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset_state();
		t_controlled();
		t_timebase();
		t_external();
		t_overflow();
		t_overrun();
		print_verdict();
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		$display("ERROR watchdog expected done seen hang");
		print_verdict();
	end
endmodule
